// *** include/parity_report_pkg.sv ***
// Purpose: Shared types and constants for bridge data parity reporting
// Assumes: One clock; parity events arrive as one-cycle pulses
// Notes:   Register offsets are word indices on the plain register port
package parity_report_pkg;

  // ==========================================================
  // Transaction description
  localparam logic [1:0] KIND_READ    = 2'h0;
  localparam logic [1:0] KIND_POSTED  = 2'h1;
  localparam logic [1:0] KIND_DELAYED = 2'h2;

  typedef struct packed {
    logic       valid;       // Transaction phase active this cycle
    logic [1:0] kind;        // Read, posted write or delayed write
    logic       upstream;    // 1: secondary to primary
    logic       err_prim;    // Parity error seen on primary data
    logic       err_sec;     // Parity error seen on secondary data
    logic       perr_prim_in; // Primary error pin sampled low (active high here)
    logic       perr_sec_in;  // Secondary error pin sampled low (active high here)
    logic       completion;  // Completion phase of a delayed write on the target bus
  } xact_s;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;

  localparam int CTRL_PRI_RESP_BIT = 0;
  localparam int CTRL_SEC_RESP_BIT = 1;

  localparam int ST_PRI_MDPD_BIT = 0;
  localparam int ST_SEC_MDPD_BIT = 1;
  localparam int ST_SEC_DPE_BIT  = 2;

  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [2:0]  STATUS_RESET = 3'h0;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

  typedef struct packed {
    logic [1:0]  ctrl_r;
    logic [2:0]  status_r;
    logic [31:0] rdata_r;
    logic        pri_pin_r;   // 1 while primary pin asserted (low on wire)
    logic        sec_pin_r;
  } state_s;

endpackage

// *** design/parity_report.sv ***
// Purpose: Master data parity status bits and error pin drive for both bus sides
// Assumes: Transaction inputs are synchronous to SYS_CLK; one cycle per data phase
// Notes:   Pins are driven one cycle after the qualifying data phase
//
// Overview of operation
// RULE1: Primary master parity bit set only when mastering primary with primary enable on.
// RULE2: It sets on sampled primary error pin low or own primary parity error.
// RULE3: Only upstream read, posted, delayed writes with primary error and enable.
// RULE4: Secondary master parity bit set only when mastering secondary with secondary enable.
// RULE5: It sets on sampled secondary error pin low or own secondary parity error.
// RULE6: Only downstream read, posted, delayed writes with secondary error and enable.
// RULE7: Primary error pin driven only as primary write target or read initiator.
// RULE8: Primary error pin asserted only with primary response enable set.
// RULE9: Primary pin asserts on parity error in data received on primary.
// RULE10: Also on secondary pin low completing downstream delayed write.
// RULE11: That case needs both enables and no primary-side error.
// RULE12: Primary pin low for upstream read, downstream posted/delayed writes with primary error.
// RULE13: Secondary error pin driven only as secondary write target or read initiator.
// RULE14: Secondary error pin asserted only with secondary response enable set.
// RULE15: Secondary pin asserts on parity error in data received on secondary.
// RULE16: Also on primary pin low completing upstream delayed write.
// RULE17: Secondary detected parity bit set regardless of enables for its cases.
// RULE18: Status bits stay set until written one; reset clears them.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module parity_report (
  // Clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    RST_N,
  // Transaction observation
  input  wire parity_report_pkg::xact_s XACT,
  // Register port
  input  wire logic [3:0]              REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic [31:0]                  REG_RDATA,
  // Primary parity error pin (open drain)
  output logic                         PRI_PERR_O,
  output logic                         PRI_PERR_OE_N,
  // Secondary parity error pin (open drain)
  output logic                         SEC_PERR_O,
  output logic                         SEC_PERR_OE_N
);

  parity_report_pkg::state_s st_r;
  parity_report_pkg::state_s st_nxt;

  logic pri_en;
  logic sec_en;
  logic is_rd;
  logic is_pw;
  logic is_dw;
  logic up;
  logic set_pri_mdpd;
  logic set_sec_mdpd;
  logic set_sec_dpe;
  logic pri_pin_req;
  logic sec_pin_req;
  logic [2:0] set_vec;
  logic [2:0] clr_vec;

  // ============================================================
  // Event decode
  always_comb begin
    pri_en = st_r.ctrl_r[parity_report_pkg::CTRL_PRI_RESP_BIT];
    sec_en = st_r.ctrl_r[parity_report_pkg::CTRL_SEC_RESP_BIT];
    is_rd  = XACT.valid && (XACT.kind == parity_report_pkg::KIND_READ);
    is_pw  = XACT.valid && (XACT.kind == parity_report_pkg::KIND_POSTED);
    is_dw  = XACT.valid && (XACT.kind == parity_report_pkg::KIND_DELAYED);
    up     = XACT.upstream;
    // Bridge masters primary on upstream traffic, secondary on downstream
    set_pri_mdpd = (is_rd || is_pw || is_dw) && up && pri_en        // RULE1 RULE3
                   && (XACT.err_prim || XACT.perr_prim_in);        // RULE2
    set_sec_mdpd = (is_rd || is_pw || is_dw) && !up && sec_en       // RULE4 RULE6
                   && (XACT.err_sec || XACT.perr_sec_in);          // RULE5
    set_sec_dpe  = XACT.err_sec && ((is_rd && !up) || ((is_pw || is_dw) && up)); // RULE17
    // Primary receives data: upstream read initiator or downstream write target
    pri_pin_req  = pri_en && (                                     // RULE8
                     (XACT.err_prim && ((is_rd && up) || ((is_pw || is_dw) && !up))) // RULE7 RULE9 RULE12
                   || (is_dw && !up && XACT.completion && XACT.perr_sec_in // RULE10
                       && sec_en && !XACT.err_prim));              // RULE11
    sec_pin_req  = sec_en && (                                     // RULE14
                     (XACT.err_sec && ((is_rd && !up) || ((is_pw || is_dw) && up))) // RULE13 RULE15
                   || (is_dw && up && XACT.completion && XACT.perr_prim_in
                       && pri_en && !XACT.err_sec));               // RULE16
    set_vec = {set_sec_dpe, set_sec_mdpd, set_pri_mdpd};
  end

  // ============================================================
  // Next state
  always_comb begin
    st_nxt  = st_r;
    clr_vec = '0;
    if (REG_WR && REG_ADDR == parity_report_pkg::ADDR_CTRL) begin
      st_nxt.ctrl_r = REG_WDATA[1:0];
    end
    if (REG_WR && REG_ADDR == parity_report_pkg::ADDR_STATUS) begin
      clr_vec = REG_WDATA[2:0];
    end
    // A set in the same cycle as a clear wins
    st_nxt.status_r = (st_r.status_r & ~clr_vec) | set_vec; // RULE18
    if (REG_RD) begin
      unique case (REG_ADDR)
        parity_report_pkg::ADDR_CTRL:   st_nxt.rdata_r = {30'h0, st_r.ctrl_r};
        parity_report_pkg::ADDR_STATUS: st_nxt.rdata_r = {29'h0, st_r.status_r};
        default:                        st_nxt.rdata_r = parity_report_pkg::UNMAPPED_VAL;
      endcase
    end else begin
      st_nxt.rdata_r = parity_report_pkg::UNMAPPED_VAL;
    end
    st_nxt.pri_pin_r = pri_pin_req;
    st_nxt.sec_pin_r = sec_pin_req;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r.ctrl_r    <= parity_report_pkg::CTRL_RESET;
      st_r.status_r  <= parity_report_pkg::STATUS_RESET;
      st_r.rdata_r   <= parity_report_pkg::UNMAPPED_VAL;
      st_r.pri_pin_r <= 1'b0;
      st_r.sec_pin_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs: open drain, enable low while pulling the wire low
  assign REG_RDATA     = st_r.rdata_r;
  assign PRI_PERR_O    = 1'b0;
  assign PRI_PERR_OE_N = !st_r.pri_pin_r; // RULE7
  assign SEC_PERR_O    = 1'b0;
  assign SEC_PERR_OE_N = !st_r.sec_pin_r; // RULE13

  // ============================================================
  // Checks
  sequence up_pri_err;
    XACT.valid && XACT.upstream && XACT.err_prim;
  endsequence

  AST_PRI_MDPD_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE1
    set_pri_mdpd |-> pri_en && up) else $error("primary master bit set without enable");
  AST_PRI_MDPD_SETS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE2
    (up_pri_err and pri_en) |=> st_r.status_r[parity_report_pkg::ST_PRI_MDPD_BIT])
    else $error("primary master bit not set");
  AST_PRI_MDPD_DOWN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE3
    (XACT.valid && !up) |-> !set_pri_mdpd) else $error("primary master bit on downstream");
  AST_SEC_MDPD_NEEDS_EN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE4
    set_sec_mdpd |-> sec_en && !up) else $error("secondary master bit set without enable");
  AST_SEC_MDPD_SETS: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE5
    (XACT.valid && !up && sec_en && XACT.perr_sec_in)
    |=> st_r.status_r[parity_report_pkg::ST_SEC_MDPD_BIT]) else $error("secondary bit missed");
  AST_SEC_MDPD_UP: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE6
    (XACT.valid && up) |-> !set_sec_mdpd) else $error("secondary master bit on upstream");
  AST_PRI_PIN_WINDOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE7
    !PRI_PERR_OE_N |-> $past(XACT.valid)) else $error("primary pin driven outside transfer");
  AST_PRI_PIN_EN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE8
    !PRI_PERR_OE_N |-> $past(pri_en)) else $error("primary pin without enable");
  AST_PRI_PIN_UPRD: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE12
    (is_rd && up && XACT.err_prim && pri_en) |=> !PRI_PERR_OE_N)
    else $error("primary pin not asserted on upstream read");
  AST_PRI_PIN_DW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE11
    (is_dw && !up && XACT.completion && XACT.perr_sec_in && !sec_en && !XACT.err_prim)
    |=> PRI_PERR_OE_N) else $error("primary pin on delayed write without both enables");
  AST_SEC_PIN_EN: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE14
    !SEC_PERR_OE_N |-> $past(sec_en)) else $error("secondary pin without enable");
  AST_SEC_PIN_UPPW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE15
    (is_pw && up && XACT.err_sec && sec_en) |=> !SEC_PERR_OE_N)
    else $error("secondary pin not asserted on upstream posted write");
  AST_SEC_DPE: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE17
    (is_rd && !up && XACT.err_sec) |=> st_r.status_r[parity_report_pkg::ST_SEC_DPE_BIT])
    else $error("secondary detected bit missed");
  AST_STATUS_STICKY: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE18
    (st_r.status_r[parity_report_pkg::ST_PRI_MDPD_BIT]
     && !(REG_WR && REG_ADDR == parity_report_pkg::ADDR_STATUS
     && REG_WDATA[parity_report_pkg::ST_PRI_MDPD_BIT]))
    |=> st_r.status_r[parity_report_pkg::ST_PRI_MDPD_BIT]) else $error("status bit lost");

  // ============================================================
  // Pin drive checks for received data and delayed write completion
  sequence down_pw_pri_err;
    is_pw && !up && XACT.err_prim && pri_en;
  endsequence

  sequence up_dw_far_pin;
    is_dw && up && XACT.completion && XACT.perr_prim_in && pri_en && sec_en && !XACT.err_sec;
  endsequence

  AST_PRI_PIN_DNPW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE9
    down_pw_pri_err |=> !PRI_PERR_OE_N) else $error("primary pin not asserted on posted write");
  AST_PRI_PIN_DWCMP: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE10
    (is_dw && !up && XACT.completion && XACT.perr_sec_in && pri_en && sec_en && !XACT.err_prim)
    |=> !PRI_PERR_OE_N) else $error("primary pin missed on delayed write completion");
  AST_SEC_PIN_WINDOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE13
    !SEC_PERR_OE_N |-> $past(XACT.valid)) else $error("secondary pin driven outside transfer");
  AST_SEC_PIN_DWCMP: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE16
    up_dw_far_pin |=> !SEC_PERR_OE_N) else $error("secondary pin missed on delayed completion");

endmodule

// *** tb/bus_partner.sv ***
// Purpose: Far-side bus agents presenting data phases and watching error pins
// Assumes: Both error pins are open drain with board pull-ups
// Notes:   A released pin reads high, never its last driven value
`timescale 1ns/1ps
module bus_partner (
  // Clock
  input  wire logic                SYS_CLK,
  // Data phase seen by the bridge
  output parity_report_pkg::xact_s XACT,
  // Error pins
  input  wire logic                PRI_O,
  input  wire logic                PRI_OE_N,
  input  wire logic                SEC_O,
  input  wire logic                SEC_OE_N,
  output logic                     PRI_LEVEL,
  output logic                     SEC_LEVEL
);
  // ==========================================================
  // Pin resolution
  assign PRI_LEVEL = PRI_OE_N ? 1'b1 : PRI_O;
  assign SEC_LEVEL = SEC_OE_N ? 1'b1 : SEC_O;

  initial XACT = '0;

  // ==========================================================
  // One data phase, then the bus goes idle
  task automatic phase(input parity_report_pkg::xact_s t);
    @(posedge SYS_CLK);
    XACT <= t;
    @(posedge SYS_CLK);
    XACT <= '0;
  endtask
endmodule

// *** tb/test_bridge_data_parity_reporting.sv ***
// Purpose: Self-checking bench for parity status bits and error pin drive
// Assumes: Pins are checked one cycle after the data phase
// Notes:   Expectations are rebuilt from direction, kind and enables
`timescale 1ns/1ps
module test_bridge_data_parity_reporting;
  logic                     sys_clk, rst_n, reg_wr, reg_rd;
  logic [3:0]               reg_addr;
  logic [31:0]              reg_wdata, reg_rdata;
  logic                     pri_o, pri_oe_n, sec_o, sec_oe_n, pri_level, sec_level;
  parity_report_pkg::xact_s xact;
  int                       fail_count = 0;
  int                       comparisons = 0;

  parity_report i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .XACT(xact), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .PRI_PERR_O(pri_o), .PRI_PERR_OE_N(pri_oe_n), .SEC_PERR_O(sec_o), .SEC_PERR_OE_N(sec_oe_n));
  bus_partner i_partner (.SYS_CLK(sys_clk), .XACT(xact), .PRI_O(pri_o), .PRI_OE_N(pri_oe_n),
    .SEC_O(sec_o), .SEC_OE_N(sec_oe_n), .PRI_LEVEL(pri_level), .SEC_LEVEL(sec_level));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 check(what, exp, reg_rdata);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // One data phase against freshly cleared status
  task automatic run_case(input logic [1:0] k, input logic up, ep, es, pp, ps, cmp,
                          input logic [1:0] en);
    logic w, pm, sm, sd, pa, sa;
    w  = (k != parity_report_pkg::KIND_READ);
    pm = up && en[0] && (ep || pp);
    sm = !up && en[1] && (es || ps);
    sd = es && (w == up);
    pa = (en[0] && ep && (w != up)) || (k == parity_report_pkg::KIND_DELAYED && !up && cmp
         && ps && en == 2'h3 && !ep);
    sa = (en[1] && es && (w == up)) || (k == parity_report_pkg::KIND_DELAYED && up && cmp
         && pp && en == 2'h3 && !es);
    reg_write(parity_report_pkg::ADDR_STATUS, 32'h0000_0007);
    reg_write(parity_report_pkg::ADDR_CTRL, {30'h0, en});
    i_partner.phase({1'b1, k, up, ep, es, pp, ps, cmp});
    #1 check("primary pin", {31'h0, !pa}, {31'h0, pri_level});
    check("secondary pin", {31'h0, !sa}, {31'h0, sec_level});
    reg_read(parity_report_pkg::ADDR_STATUS, {29'h0, sd, sm, pm}, "status");
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_registers();
    reg_read(parity_report_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    reg_read(parity_report_pkg::ADDR_STATUS, 32'h0, "status reset");
    reg_write(parity_report_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    reg_write(4'hF, 32'hFFFF_FFFF);
    reg_read(parity_report_pkg::ADDR_CTRL, 32'h0000_0003, "ctrl");
    reg_read(4'hF, 32'h0, "unmapped");
  endtask
  task automatic test_table_sweep();
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 16; c++)
        run_case(k[1:0], c[0], !c[1], c[1], 1'b0, 1'b0, 1'b0, c[3:2]);
  endtask
  task automatic test_far_pins();
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 32; c++)
        run_case(k[1:0], c[0], 1'b0, 1'b0, c[1], c[2], 1'b1, c[4:3]);
  endtask
  task automatic test_sticky();
    reg_write(parity_report_pkg::ADDR_CTRL, 32'h0000_0003);
    i_partner.phase({1'b1, parity_report_pkg::KIND_POSTED, 1'b1, 1'b1, 1'b1, 3'h0});
    reg_read(parity_report_pkg::ADDR_STATUS, 32'h0000_0005, "status set");
    reg_write(parity_report_pkg::ADDR_STATUS, 32'h0000_0002);
    reg_read(parity_report_pkg::ADDR_STATUS, 32'h0000_0005, "status held");
    reg_write(parity_report_pkg::ADDR_STATUS, 32'h0000_0001);
    reg_read(parity_report_pkg::ADDR_STATUS, 32'h0000_0004, "status part clear");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_registers();
    test_table_sweep();
    test_far_pins();
    test_sticky();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule
